// File: design/qsf_pkg.sv
// Constants, command codes and link states for the serial flash front end.
package qsf_pkg;
  // System clock and timing figures.
  localparam int CLK_PERIOD_NS = 40;
  localparam int HARD_CLEAR_MIN_NS = 1000;
  localparam int HARD_CLEAR_CYCLES = (HARD_CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_RESET_NS = 30000;
  localparam int SW_RESET_CYCLES = SW_RESET_NS / CLK_PERIOD_NS;

  // Command codes seen by the front end.
  localparam logic [7:0] CMD_DUAL_OUT = 8'h3B;
  localparam logic [7:0] CMD_DUAL_IO = 8'hBB;
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
  localparam logic [7:0] CMD_QUAD_IO = 8'hEB;
  localparam logic [7:0] CMD_QUAD_WORD = 8'hE7;
  localparam logic [7:0] CMD_QUAD_OCTAL = 8'hE3;
  localparam logic [7:0] CMD_ENTER_FOUR_LANE = 8'h38;
  localparam logic [7:0] CMD_EXIT_FOUR_LANE = 8'hFF;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET = 8'h99;

  // Bytes taken in after the command code before the device turns to output.
  localparam logic [2:0] IN_BYTES_DUAL_OUT = 3'h4;
  localparam logic [2:0] IN_BYTES_DUAL_IO = 3'h4;
  localparam logic [2:0] IN_BYTES_QUAD_OUT = 3'h4;
  localparam logic [2:0] IN_BYTES_QUAD_IO = 3'h6;
  localparam logic [2:0] IN_BYTES_QUAD_WORD = 3'h5;
  localparam logic [2:0] IN_BYTES_QUAD_OCTAL = 3'h4;

  // Lane widths in bits per serial clock, and bits per byte.
  localparam logic [3:0] LW_ONE = 4'h1;
  localparam logic [3:0] LW_TWO = 4'h2;
  localparam logic [3:0] LW_FOUR = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_COUNT = 4'h0;

  // Link phases, one-hot.
  typedef enum logic [3:0] {
    QSF_ST_CMD = 4'b0001,
    QSF_ST_IN = 4'b0010,
    QSF_ST_OUT = 4'b0100,
    QSF_ST_SKIP = 4'b1000
  } qsf_state_e;
endpackage : qsf_pkg

// File: design/qsf_front_end.sv
// Serial front end of a quad serial flash: lanes, modes, pause and clears.
// How it works
// - Single-lane: instruction, address and data bits sampled on rising serial clock.
// - Single-lane: read data shifted out on lane1, changing on falling clock.
// - Clock idles low (mode 0) or high (mode 3) at select edges; both work.
// - Commands 3Bh and BBh use lanes 0 and 1, two bits per clock.
// - Commands 6Bh, EBh, E7h, E3h use lanes 0 to 3; protect and pause pins become lanes.
// - Four-lane commands run only while quad_io_enable is set.
// - 38h enters four-lane command mode; FFh returns to SPI modes.
// - Command code takes eight clocks on one lane, two clocks on four lanes.
// - Exactly one of SPI mode and four-lane command mode is active.
// - Power-up and software reset leave the device in SPI mode.
// - Four-lane command mode is entered only with quad_io_enable set.
// - Pause exists only in one/two-lane use; quad_io_enable turns pin into lane3.
// - Pause starts at once if clock low, else after next falling clock.
// - Pause ends at once if clock low, else after next falling clock.
// - While paused, output floats, input and clock ignored, state kept.
// - 66h then 99h resets the device; no command accepted for about 30 us.
// - Role bit: pin is pause input at 0, active-low hardware clear at 1.
// - Clear held low at least 1 us restores power-on state; no commands meanwhile.
// - With quad_io_enable set the shared pin is only a data lane.
// - Dedicated clear pin works regardless of role bit and quad_io_enable.
// - Hardware clear overrides every other input and aborts all operations.
// - While deselected all serial data outputs are high impedance.
// - After power-up a high-to-low select edge is needed before any command.
`timescale 1ns/1ns
`default_nettype none
module qsf_front_end #(
  parameter bit DEDICATED_CLEAR = 1'b1,
  parameter int HCLR_CYCLES = qsf_pkg::HARD_CLEAR_CYCLES,
  parameter int SWR_CYCLES = qsf_pkg::SW_RESET_CYCLES
) (
  input wire logic clk_in, // System clock, 25 MHz.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic sclk_in, // Serial clock from the controller.
  input wire logic cs_n_in, // Chip select, active low.
  input wire logic [3:0] lane_in, // Levels seen on lane3..lane0.
  output logic [3:0] lane_out, // Values driven on lane3..lane0.
  output logic [3:0] lane_oe_out, // Drive enables for lane3..lane0.
  input wire logic hard_clear_n_in, // Dedicated hardware clear pin, active low.
  input wire logic quad_io_enable_in, // Nonvolatile quad_io_enable bit.
  input wire logic hold_is_clear_in, // Shared pin role: 0 pause, 1 hardware clear.
  input wire logic [7:0] tx_byte_in, // Byte to send on read phases.
  input wire logic tx_load_in, // Pulse loading tx_byte_in.
  output logic [7:0] cmd_code_out, // Last accepted command code.
  output logic cmd_valid_out, // Pulse when cmd_code_out is new.
  output logic four_lane_command_mode_out, // High in four-lane command mode.
  output logic reset_busy_out, // High while a clear or reset holds the device.
  output logic device_clear_out // Pulse when a clear or reset completes.
);

  localparam int HCW = $clog2(HCLR_CYCLES + 1);
  localparam int SWW = $clog2(SWR_CYCLES + 1);

  // Refuse counts that the counters cannot serve.
  if (HCLR_CYCLES < 1 || SWR_CYCLES < 1) begin : g_bad_counts
    $error("Clear and reset counts must be at least one cycle.");
  end

  // System-domain state.
  logic qe_s1, qe_s2, role_s1, role_s2;
  logic dclr_s1, dclr_s2, l3_s1, l3_s2, cs_s1, cs_s2;
  logic ctog_s1, ctog_s2, ctog_seen, stog_s1, stog_s2, stog_seen;
  logic qpi_s1, qpi_s2;
  logic [HCW-1:0] hc_cnt;
  logic [SWW-1:0] swr_cnt;
  logic mode_clr, next_mode_clr, sel_ok;
  logic [7:0] tx_hold;
  logic clear_low;

  // Link-domain state.
  qsf_pkg::qsf_state_e state, next_state;
  logic [3:0] cnt, in_w, out_w, cmd_w, next_in_w, next_out_w, cnt_next;
  logic [2:0] bytes_left, next_bytes;
  logic [7:0] rx_sh, rx_next, out_sh;
  logic [3:0] out_cnt, lane_q;
  logic out_on, pause_r, four_lane_command_mode, arm, cmd_tog, swr_tog;
  logic [7:0] cmd_code_l;
  logic link_rst, hold_ok, paused_pos, pause_eff, byte_done, cmd_done, refuse, quad_cmd;

  // Append the lanes of one clock below the bits already held.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] l,
                                          input logic [3:0] w);
    case (w)
      qsf_pkg::LW_TWO: shift_in = {sh[5:0], l[1:0]};
      qsf_pkg::LW_FOUR: shift_in = {sh[3:0], l[3:0]};
      default: shift_in = {sh[6:0], l[0]};
    endcase
  endfunction : shift_in

  // Place the top bits of a byte onto the lanes for the given width.
  function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [3:0] w);
    case (w)
      qsf_pkg::LW_TWO: top_bits = {2'h0, b[7:6]};
      qsf_pkg::LW_FOUR: top_bits = b[7:4];
      default: top_bits = {2'h0, b[7], 1'b0};
    endcase
  endfunction : top_bits

  // Lanes that the device drives for an output width.
  function automatic logic [3:0] oe_mask(input logic [3:0] w);
    case (w)
      qsf_pkg::LW_TWO: oe_mask = 4'h3;
      qsf_pkg::LW_FOUR: oe_mask = 4'hF;
      default: oe_mask = 4'h2;
    endcase
  endfunction : oe_mask

  // Two-flop synchronisers for pins and for toggles from the link.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {qe_s1, qe_s2, role_s1, role_s2} <= 4'h0;
      {dclr_s1, dclr_s2, l3_s1, l3_s2, cs_s1, cs_s2} <= 6'h3F;
      {ctog_s1, ctog_s2, stog_s1, stog_s2, qpi_s1, qpi_s2} <= 6'h00;
    end else begin
      qe_s1 <= quad_io_enable_in;
      qe_s2 <= qe_s1;
      role_s1 <= hold_is_clear_in;
      role_s2 <= role_s1;
      dclr_s1 <= hard_clear_n_in;
      dclr_s2 <= dclr_s1;
      l3_s1 <= lane_in[3];
      l3_s2 <= l3_s1;
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      ctog_s1 <= cmd_tog;
      ctog_s2 <= ctog_s1;
      stog_s1 <= swr_tog;
      stog_s2 <= stog_s1;
      qpi_s1 <= four_lane_command_mode;
      qpi_s2 <= qpi_s1;
    end
  end

  // Hardware clear request: dedicated pin always, shared pin only by role.
  assign clear_low = (DEDICATED_CLEAR & ~dclr_s2)
                   | (role_s2 & ~qe_s2 & ~qpi_s2 & ~l3_s2);

  // Count how long the clear input has stayed low.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hc_cnt <= '0;
    end else if (!clear_low) begin
      hc_cnt <= '0;
    end else if (hc_cnt != HCW'(HCLR_CYCLES)) begin
      hc_cnt <= hc_cnt + HCW'(1);
    end
  end

  // Software reset period, started by the accepted 66h-99h pair.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      swr_cnt <= '0;
      stog_seen <= 1'b0;
    end else begin
      stog_seen <= stog_s2;
      if (stog_s2 != stog_seen && !mode_clr) begin
        swr_cnt <= SWW'(SWR_CYCLES);
      end else if (swr_cnt != '0) begin
        swr_cnt <= swr_cnt - SWW'(1);
      end
    end
  end

  // Device clear level: power-up, qualified hardware clear or reset period.
  assign next_mode_clr = (hc_cnt == HCW'(HCLR_CYCLES)) | (swr_cnt != '0);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_clr <= 1'b1;
      device_clear_out <= 1'b0;
    end else begin
      mode_clr <= next_mode_clr;
      device_clear_out <= mode_clr & ~next_mode_clr;
    end
  end

  // A select high level must be seen after any clear before commands count.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sel_ok <= 1'b0;
    end else if (mode_clr) begin
      sel_ok <= 1'b0;
    end else if (cs_s2) begin
      sel_ok <= 1'b1;
    end
  end

  // Command report toward the system side.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctog_seen <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= qsf_pkg::RST_BYTE;
    end else begin
      ctog_seen <= ctog_s2;
      cmd_valid_out <= (ctog_s2 != ctog_seen) & ~mode_clr;
      if (ctog_s2 != ctog_seen) begin
        cmd_code_out <= cmd_code_l;
      end
    end
  end

  // Transmit byte held for the link and status levels.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_hold <= qsf_pkg::RST_BYTE;
      four_lane_command_mode_out <= 1'b0;
      reset_busy_out <= 1'b1;
    end else begin
      if (tx_load_in) begin
        tx_hold <= tx_byte_in;
      end
      four_lane_command_mode_out <= qpi_s2;
      reset_busy_out <= mode_clr;
    end
  end

  // Link reset: deselect, clear pins or device clear; clear pins act at once.
  assign link_rst = cs_n_in | mode_clr
                  | (DEDICATED_CLEAR & ~hard_clear_n_in)
                  | (role_s2 & ~qe_s2 & ~four_lane_command_mode & ~lane_in[3]);
  assign refuse = mode_clr | ~sel_ok | (quad_cmd & ~qe_s2);

  // Pause applies only in one/two-lane SPI use with the pin in pause role.
  assign hold_ok = ~qe_s2 & ~role_s2 & ~four_lane_command_mode;
  assign paused_pos = hold_ok & ~lane_in[3];
  assign pause_eff = hold_ok & (sclk_in ? pause_r : ~lane_in[3]);

  // Command width and byte assembly.
  assign cmd_w = four_lane_command_mode ? qsf_pkg::LW_FOUR : qsf_pkg::LW_ONE;
  assign rx_next = shift_in(rx_sh, lane_in, (state == qsf_pkg::QSF_ST_CMD) ? cmd_w : in_w);
  assign cnt_next = cnt + ((state == qsf_pkg::QSF_ST_CMD) ? cmd_w : in_w);
  assign byte_done = (cnt_next == qsf_pkg::BITS_PER_BYTE);
  assign cmd_done = (state == qsf_pkg::QSF_ST_CMD) & byte_done & ~paused_pos;
  assign quad_cmd = (rx_next == qsf_pkg::CMD_QUAD_OUT) | (rx_next == qsf_pkg::CMD_QUAD_IO)
                  | (rx_next == qsf_pkg::CMD_QUAD_WORD) | (rx_next == qsf_pkg::CMD_QUAD_OCTAL);

  // Decode a finished command code into the phases that follow.
  always_comb begin
    next_state = four_lane_command_mode ? qsf_pkg::QSF_ST_SKIP : qsf_pkg::QSF_ST_OUT;
    next_in_w = qsf_pkg::LW_ONE;
    next_out_w = qsf_pkg::LW_ONE;
    next_bytes = 3'h1;
    if (refuse) begin
      next_state = qsf_pkg::QSF_ST_SKIP;
    end else begin
      case (rx_next)
        qsf_pkg::CMD_DUAL_OUT: begin
          next_state = qsf_pkg::QSF_ST_IN;
          next_out_w = qsf_pkg::LW_TWO;
          next_bytes = qsf_pkg::IN_BYTES_DUAL_OUT;
        end
        qsf_pkg::CMD_DUAL_IO: begin
          next_state = qsf_pkg::QSF_ST_IN;
          next_in_w = qsf_pkg::LW_TWO;
          next_out_w = qsf_pkg::LW_TWO;
          next_bytes = qsf_pkg::IN_BYTES_DUAL_IO;
        end
        qsf_pkg::CMD_QUAD_OUT: begin
          next_state = qsf_pkg::QSF_ST_IN;
          next_out_w = qsf_pkg::LW_FOUR;
          next_bytes = qsf_pkg::IN_BYTES_QUAD_OUT;
        end
        qsf_pkg::CMD_QUAD_IO, qsf_pkg::CMD_QUAD_WORD, qsf_pkg::CMD_QUAD_OCTAL: begin
          next_state = qsf_pkg::QSF_ST_IN;
          next_in_w = qsf_pkg::LW_FOUR;
          next_out_w = qsf_pkg::LW_FOUR;
          next_bytes = (rx_next == qsf_pkg::CMD_QUAD_IO) ? qsf_pkg::IN_BYTES_QUAD_IO :
                       (rx_next == qsf_pkg::CMD_QUAD_WORD) ? qsf_pkg::IN_BYTES_QUAD_WORD :
                       qsf_pkg::IN_BYTES_QUAD_OCTAL;
        end
        qsf_pkg::CMD_ENTER_FOUR_LANE, qsf_pkg::CMD_EXIT_FOUR_LANE,
        qsf_pkg::CMD_RESET_ENABLE, qsf_pkg::CMD_RESET: begin
          next_state = qsf_pkg::QSF_ST_SKIP;
        end
        default: begin
        end
      endcase
      if (four_lane_command_mode && next_in_w != qsf_pkg::LW_FOUR) begin
        next_state = qsf_pkg::QSF_ST_SKIP;
      end
    end
  end

  // Rising serial clock: sample lanes, count bits, step the phase.
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      state <= qsf_pkg::QSF_ST_CMD;
      cnt <= qsf_pkg::RST_COUNT;
      rx_sh <= qsf_pkg::RST_BYTE;
      in_w <= qsf_pkg::LW_ONE;
      out_w <= qsf_pkg::LW_ONE;
      bytes_left <= 3'h0;
      pause_r <= 1'b0;
    end else begin
      pause_r <= paused_pos;
      if (!paused_pos) begin
        case (state)
          qsf_pkg::QSF_ST_CMD: begin
            rx_sh <= rx_next;
            cnt <= byte_done ? qsf_pkg::RST_COUNT : cnt_next;
            if (byte_done) begin
              state <= next_state;
              in_w <= next_in_w;
              out_w <= next_out_w;
              bytes_left <= next_bytes;
            end
          end
          qsf_pkg::QSF_ST_IN: begin
            rx_sh <= rx_next;
            cnt <= byte_done ? qsf_pkg::RST_COUNT : cnt_next;
            if (byte_done) begin
              bytes_left <= bytes_left - 3'h1;
              if (bytes_left == 3'h1) begin
                state <= qsf_pkg::QSF_ST_OUT;
              end
            end
          end
          qsf_pkg::QSF_ST_OUT, qsf_pkg::QSF_ST_SKIP: begin
            state <= state;
          end
          default: begin
            state <= qsf_pkg::QSF_ST_SKIP;
          end
        endcase
      end
    end
  end

  // Mode, reset arming and command report; kept across frames.
  always_ff @(posedge sclk_in or posedge mode_clr) begin
    if (mode_clr) begin
      four_lane_command_mode <= 1'b0;
      arm <= 1'b0;
      cmd_tog <= 1'b0;
      swr_tog <= 1'b0;
      cmd_code_l <= qsf_pkg::RST_BYTE;
    end else if (cmd_done && !refuse && !link_rst) begin
      cmd_tog <= ~cmd_tog;
      cmd_code_l <= rx_next;
      arm <= (rx_next == qsf_pkg::CMD_RESET_ENABLE);
      if (rx_next == qsf_pkg::CMD_RESET && arm) begin
        swr_tog <= ~swr_tog;
      end
      if (rx_next == qsf_pkg::CMD_ENTER_FOUR_LANE && qe_s2) begin
        four_lane_command_mode <= 1'b1;
      end else if (rx_next == qsf_pkg::CMD_EXIT_FOUR_LANE) begin
        four_lane_command_mode <= 1'b0;
      end
    end
  end

  // Falling serial clock: shift the transmit byte onto the lanes.
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      out_on <= 1'b0;
      out_sh <= qsf_pkg::RST_BYTE;
      out_cnt <= qsf_pkg::RST_COUNT;
      lane_q <= 4'h0;
    end else if (!pause_r) begin
      if (state == qsf_pkg::QSF_ST_OUT) begin
        out_on <= 1'b1;
        if (out_cnt == qsf_pkg::RST_COUNT) begin
          lane_q <= top_bits(tx_hold, out_w);
          out_sh <= tx_hold << out_w;
          out_cnt <= qsf_pkg::BITS_PER_BYTE - out_w;
        end else begin
          lane_q <= top_bits(out_sh, out_w);
          out_sh <= out_sh << out_w;
          out_cnt <= out_cnt - out_w;
        end
      end else begin
        out_on <= 1'b0;
      end
    end
  end

  // Lane drive: floated when deselected, cleared or paused.
  assign lane_out = lane_q;
  assign lane_oe_out = (out_on && !link_rst && !pause_eff) ? oe_mask(out_w) : 4'h0;

endmodule : qsf_front_end
`default_nettype wire

// File: dv/qsf_front_end_chk.sv
// Concurrent checks on the serial flash front end ports.
`timescale 1ns/1ns
`default_nettype none
module qsf_front_end_chk #(
  parameter int HCLR_CYCLES = 25
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic sclk_in, // Serial clock.
  input wire logic cs_n_in, // Chip select, active low.
  input wire logic [3:0] lane_in, // Lane levels.
  input wire logic [3:0] lane_oe_out, // Lane drive enables.
  input wire logic hard_clear_n_in, // Dedicated clear pin.
  input wire logic quad_io_enable_in, // Quad enable bit.
  input wire logic hold_is_clear_in, // Shared pin role.
  input wire logic cmd_valid_out, // Command report pulse.
  input wire logic four_lane_command_mode_out, // Four-lane mode.
  input wire logic reset_busy_out, // Clear in progress.
  input wire logic device_clear_out // Clear finished.
);
  logic [7:0] low_cnt; // Cycles the dedicated clear pin has been low.
  // Counts clear-pin low time, saturating so long holds stay valid.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || hard_clear_n_in)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_paused;
    !cs_n_in && !quad_io_enable_in && !hold_is_clear_in && !lane_in[3] && !sclk_in;
  endsequence
  sequence s_done;
    reset_busy_out ##1 !reset_busy_out && !device_clear_out;
  endsequence
  property p_float; cs_n_in |-> lane_oe_out == 4'h0; endproperty
  property p_pause; s_paused ##1 s_paused |-> lane_oe_out == 4'h0; endproperty
  property p_narrow; !quad_io_enable_in |-> lane_oe_out[3:2] == 2'b00; endproperty
  property p_enter; $rose(four_lane_command_mode_out) |-> quad_io_enable_in; endproperty
  property p_busy; reset_busy_out [*6] |-> !cmd_valid_out; endproperty
  property p_held; !hard_clear_n_in [*6] |-> !cmd_valid_out; endproperty
  property p_long; low_cnt == 8'(HCLR_CYCLES + 6) |-> reset_busy_out; endproperty
  property p_end; device_clear_out |-> s_done; endproperty
  property p_spi; device_clear_out |-> !four_lane_command_mode_out; endproperty
  a_float: assert property (p_float)
    else $error("lanes driven while deselected");
  a_pause: assert property (p_pause)
    else $error("lanes driven while paused");
  a_narrow: assert property (p_narrow)
    else $error("upper lanes driven without quad enable");
  a_enter: assert property (p_enter)
    else $error("four-lane mode entered without quad enable");
  a_busy: assert property (p_busy)
    else $error("command reported during reset period");
  a_held: assert property (p_held)
    else $error("command reported while clear held");
  a_long: assert property (p_long)
    else $error("long clear did not hold device");
  a_end: assert property (p_end)
    else $error("no single clear pulse after busy");
  a_spi: assert property (p_spi)
    else $error("clear left four-lane mode on");
endmodule : qsf_front_end_chk
bind qsf_front_end qsf_front_end_chk #(.HCLR_CYCLES(HCLR_CYCLES)) chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .lane_in(lane_in), .lane_oe_out(lane_oe_out), .hard_clear_n_in(hard_clear_n_in),
  .quad_io_enable_in(quad_io_enable_in), .hold_is_clear_in(hold_is_clear_in),
  .cmd_valid_out(cmd_valid_out), .four_lane_command_mode_out(four_lane_command_mode_out),
  .reset_busy_out(reset_busy_out), .device_clear_out(device_clear_out));
`default_nettype wire

// File: dv/qsf_spi_host.sv
// Serial bus controller model: clock, select and lanes at the flash front end.
`timescale 1ns/1ns
`default_nettype none
module qsf_spi_host (
  output logic sclk_out, // Serial clock, 15 ns period in frames.
  output logic cs_n_out, // Chip select, active low.
  output logic [3:0] drv_out, // Values driven on lanes.
  output logic [3:0] den_out, // Lane drive enables.
  input wire logic [3:0] wire_in, // Resolved lane levels.
  input wire logic [3:0] oe_in // Device lane enables.
);
  logic cpol; // Idle clock level: 0 for mode 0, 1 for mode 3.
  logic [3:0] pause_oe; // Device enables seen while paused.
  // Idle: deselected, protect and pause pins held high.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    drv_out = 4'hC;
    den_out = 4'hC;
    cpol = 1'b0;
    pause_oe = 4'h0;
  end
  // One clock: fall, present data, sample lanes just before the rise.
  task automatic tick(input logic [3:0] d, output logic [3:0] l);
    sclk_out = 1'b0;
    drv_out = d;
    #8;
    l = wire_in;
    sclk_out = 1'b1;
    #7;
  endtask : tick
  // Shifts one byte out on w lanes.
  task automatic put(input logic [7:0] b, input int w);
    logic [3:0] l;
    logic [7:0] s;
    den_out = (w == 1) ? 4'hD : 4'hF;
    s = b;
    for (int i = 0; i < 8 / w; i++) begin
      case (w)
        1: tick({3'b110, s[7]}, l);
        2: tick({2'b11, s[7:6]}, l);
        default: tick(s[7:4], l);
      endcase
      s = s << w;
    end
  endtask : put
  // Pause with the clock low, two ignored clocks, then release with the clock low.
  task automatic pause();
    logic [3:0] l;
    sclk_out = 1'b0;
    drv_out[3] = 1'b0;
    #50;
    pause_oe = oe_in;
    tick(4'h4, l);
    tick(4'h4, l);
    sclk_out = 1'b0;
    #50;
    drv_out[3] = 1'b1;
    #30;
  endtask : pause
  // Drives the shared pin level between frames.
  task automatic pin3(input logic v);
    drv_out[3] <= v;
  endtask : pin3
  // One frame: code, nin bytes of win lanes, then one byte read on wout lanes.
  task automatic xfer(input logic [7:0] code, input bit q, input int nin, input int win,
                      input int wout, input int pat, output logic [7:0] rd);
    logic [3:0] l;
    rd = 8'h00;
    sclk_out = cpol;
    #20;
    cs_n_out = 1'b0;
    #10;
    put(code, q ? 4 : 1);
    for (int i = 0; i < nin; i++)
      put(8'h5A, win);
    den_out = (wout == 4) ? 4'h0 : 4'hC;
    for (int i = 0; i < 8 / wout; i++) begin
      if (i == pat)
        pause();
      tick(4'hC, l);
      case (wout)
        1: rd = {rd[6:0], l[1]};
        2: rd = {rd[5:0], l[1:0]};
        default: rd = {rd[3:0], l};
      endcase
    end
    sclk_out = cpol;
    #10;
    cs_n_out = 1'b1;
    den_out = 4'hC;
    #300;
  endtask : xfer
endmodule : qsf_spi_host
`default_nettype wire

// File: dv/qsf_front_end_bench.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ns
`default_nettype none
module qsf_front_end_bench;
  localparam int HC = 8;
  logic clk_in, rst_n_in, hard_clear_n_in, quad_io_enable_in, hold_is_clear_in, tx_load_in;
  logic sclk, cs_n, tog, cmd_valid_out, four_lane_command_mode_out;
  logic reset_busy_out, device_clear_out;
  logic [3:0] lane_out, lane_oe_out, drv, den, lane_w;
  logic [7:0] tx_byte_in, cmd_code_out;
  int bad_count, checks_done, cycles;
  // Lane levels: device, then controller, else a toggling undriven pattern.
  assign lane_w = (lane_oe_out & lane_out) | (~lane_oe_out & den & drv)
                  | (~lane_oe_out & ~den & {4{tog}});
  qsf_front_end #(.HCLR_CYCLES(HC), .SWR_CYCLES(100)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n), .lane_in(lane_w),
    .lane_out(lane_out), .lane_oe_out(lane_oe_out), .hard_clear_n_in(hard_clear_n_in),
    .quad_io_enable_in(quad_io_enable_in), .hold_is_clear_in(hold_is_clear_in),
    .tx_byte_in(tx_byte_in), .tx_load_in(tx_load_in), .cmd_code_out(cmd_code_out),
    .cmd_valid_out(cmd_valid_out), .four_lane_command_mode_out(four_lane_command_mode_out),
    .reset_busy_out(reset_busy_out), .device_clear_out(device_clear_out));
  qsf_spi_host host_u (.sclk_out(sclk), .cs_n_out(cs_n), .drv_out(drv), .den_out(den),
    .wire_in(lane_w), .oe_in(lane_oe_out));
  // System clock and hang guard.
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tog <= ~tog;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Watches the command report for one frame; 00 when none.
  task automatic wcmd(output logic [7:0] c);
    c = 8'h00;
    repeat (30) begin
      @(posedge clk_in);
      if (cmd_valid_out === 1'b1)
        c = cmd_code_out;
    end
  endtask : wcmd
  task automatic frame(input logic [7:0] code, input bit q, input int nin, input int win,
                       input int wout, input int pat, output logic [7:0] rd, output logic [7:0] c);
    fork
      host_u.xfer(code, q, nin, win, wout, pat, rd);
      wcmd(c);
    join
  endtask : frame
  task automatic cfg(input logic q, input logic r);
    @(posedge clk_in);
    quad_io_enable_in <= q;
    hold_is_clear_in <= r;
    @(posedge clk_in);
  endtask : cfg
  task automatic wclear();
    logic seen;
    seen = 1'b0;
    repeat (200) begin
      @(posedge clk_in);
      if (device_clear_out === 1'b1)
        seen = 1'b1;
    end
    check("clear pulse", seen, 1'b1);
    check("mode after clear", four_lane_command_mode_out, 1'b0);
  endtask : wclear
  // Holds the dedicated or shared clear low past the minimum, expects busy or not.
  task automatic hold(input bit shared, input logic exp);
    @(posedge clk_in);
    if (shared)
      host_u.pin3(1'b0);
    else
      hard_clear_n_in <= 1'b0;
    repeat (HC + 10) @(posedge clk_in);
    check("busy in clear", reset_busy_out, exp);
    if (shared)
      host_u.pin3(1'b1);
    else
      hard_clear_n_in <= 1'b1;
  endtask : hold
  task automatic s_single();
    logic [7:0] rd, c;
    check("mode at start", four_lane_command_mode_out, 1'b0);
    frame(8'h9F, 0, 0, 1, 1, 99, rd, c);
    check("code", c, 8'h9F);
    check("single read", rd, 8'hA5);
    host_u.cpol = 1'b1;
    frame(8'h05, 0, 0, 1, 1, 3, rd, c);
    check("mode 3 paused read", rd, 8'hA5);
    check("paused enables", host_u.pause_oe, 4'h0);
    host_u.cpol = 1'b0;
  endtask : s_single
  task automatic s_wide(input logic q);
    logic [7:0] rd, c;
    logic [7:0] cd[6] = '{8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'hE3};
    int nin[6] = '{4, 4, 4, 6, 5, 4};
    int win[6] = '{1, 2, 1, 4, 4, 4};
    cfg(q, 1'b0);
    for (int i = 0; i < 6; i++) begin
      frame(cd[i], 0, nin[i], win[i], (i < 2) ? 2 : 4, 99, rd, c);
      if (!q && i >= 2) begin
        check("quad refused", c, 8'h00);
      end else begin
        check("wide code", c, cd[i]);
        check("wide read", rd, 8'hA5);
      end
    end
  endtask : s_wide
  task automatic s_modes();
    logic [7:0] rd, c;
    cfg(1'b0, 1'b0);
    frame(8'h38, 0, 0, 1, 1, 99, rd, c);
    check("enter refused", four_lane_command_mode_out, 1'b0);
    cfg(1'b1, 1'b0);
    frame(8'h38, 0, 0, 1, 1, 99, rd, c);
    check("enter", four_lane_command_mode_out, 1'b1);
    frame(8'hEB, 1, 6, 4, 4, 99, rd, c);
    check("four-lane read", rd, 8'hA5);
    frame(8'hFF, 1, 0, 4, 4, 99, rd, c);
    check("exit", four_lane_command_mode_out, 1'b0);
  endtask : s_modes
  task automatic s_clears();
    logic [7:0] rd, c;
    frame(8'h38, 0, 0, 1, 1, 99, rd, c);
    frame(8'h66, 1, 0, 4, 4, 99, rd, c);
    frame(8'h99, 1, 0, 4, 4, 99, rd, c);
    check("reset busy", reset_busy_out, 1'b1);
    frame(8'hEB, 1, 6, 4, 4, 99, rd, c);
    check("busy refusal", c, 8'h00);
    wclear();
    frame(8'h38, 0, 0, 1, 1, 99, rd, c);
    hold(1'b0, 1'b1);
    wclear();
    hold(1'b1, 1'b0);
    cfg(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    wclear();
  endtask : s_clears
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Reset, load the read byte, run the scenarios.
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    hard_clear_n_in = 1'b1;
    quad_io_enable_in = 1'b0;
    hold_is_clear_in = 1'b0;
    tx_byte_in = 8'h00;
    tx_load_in = 1'b0;
    tog = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tx_byte_in <= 8'hA5;
    tx_load_in <= 1'b1;
    @(posedge clk_in);
    tx_load_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    s_single();
    s_wide(1'b0);
    s_wide(1'b1);
    s_modes();
    s_clears();
    conclude();
  end
endmodule : qsf_front_end_bench
`default_nettype wire
